// ===== rtl/isl_pkg.sv
// Purpose: shared constants for the i2c slave engine and its bus master
// Assumes: 50 MHz mclk, open-drain scl/sda resolved in the interface
// Notes: avalon register map of the slave side
package isl_pkg;
  // register word addresses (byte address = index * 4)
  localparam logic [3:0] CTRL_IDX   = 4'h0;
  localparam logic [3:0] STAT_IDX   = 4'h1;
  localparam logic [3:0] BUF_IDX    = 4'h2;
  localparam logic [3:0] ADDR_IDX   = 4'h3;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_REL      = 4;
  localparam int CTRL_EN       = 5;
  localparam int CTRL_OV       = 6;
  localparam int CTRL_STR      = 8;
  localparam int CTRL_EVT      = 9;
  // status field positions
  localparam int ST_BF   = 0;
  localparam int ST_UA   = 1;
  localparam int ST_RW   = 2;
  localparam int ST_S    = 3;
  localparam int ST_P    = 4;
  localparam int ST_DA   = 5;
  // port modes
  localparam logic [3:0] MODE_7B    = 4'h6;
  localparam logic [3:0] MODE_10B   = 4'h7;
  localparam logic [3:0] MODE_7B_SP = 4'hE;
  localparam logic [3:0] MODE_10B_SP = 4'hF;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  // master side scl timing
  localparam int SCL_HALF_NS  = 2500;
  localparam int CLK_NS       = 20;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
endpackage

// ===== rtl/isl_bus_if.sv
// Purpose: open-drain i2c wire pair between the two ends
// Assumes: each end drives low only when its enable is high
// Notes: pull-ups modelled by resolving enables
`timescale 1ns/1ps
interface isl_bus_if;
  logic scl_oe_dev;
  logic sda_oe_dev;
  logic scl_oe_mst;
  logic sda_oe_mst;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe_dev | scl_oe_mst);
  assign sda = ~(sda_oe_dev | sda_oe_mst);
  modport dev (input scl, input sda, output scl_oe_dev, output sda_oe_dev);
  modport mst (input scl, input sda, output scl_oe_mst, output sda_oe_mst);
endinterface

// ===== rtl/isl_slave.sv
// Purpose: i2c slave engine with avalon register access
// Assumes: scl and sda come from another domain and are filtered
// Notes: scl and sda are only ever pulled low
// Operation
// - event flag on match, optionally start/stop
// - auto ack and buffer load on match
// - full or overflow: nack, no load, flag
// - buffer read clears full; overflow software cleared
// - after start, shift eight bits on scl rise
// - compare bits 7:1 at eighth fall
// - match loads buffer, full, ack, ninth-fall flag
// - ten-bit first byte is 11110 a9 a8 0
// - ten-bit address bytes set update flag
// - write address clears direction bit, acks
// - event flag once per byte, software clears
// - read address sets direction, acks, stretches
// - buffer write loads shifter; release sends data
// - transmit data changes on scl fall
// - master ack latched ninth rise; nack resets
// - stretch enable holds scl after data
// - seven-bit receive stretches only when full
// - release bit settable any time
// - ten-bit address stretch follows update flag
// - transmit stretches when buffer empty
// - third ten-bit byte enters transmit mode
// - release waits for scl low first
// - mode field 0110 0111 1110 1111
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module isl_slave (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // avalon slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // i2c pins
  isl_bus_if.dev           bus
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_TXACK, S_SKIP}
    isl_ph_t;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    isl_ph_t    ph;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] buff;
    logic [7:0] own;
    logic [3:0] mode;
    logic       en;
    logic       rel;
    logic       ov;
    logic       str;
    logic       evt;
    logic       bf;
    logic       ua;
    logic       rw;
    logic       st;
    logic       sp;
    logic       da;
    logic       hi_ok;
    logic       nak;
    logic       scl_oe;
    logic       sda_oe;
    logic       ack;
    logic [31:0] rdata;
    logic       ack_bus;
  } isl_st_t;
  isl_st_t s_reg, s_next;

  function automatic logic ten_bit(input logic [3:0] m);
    return m == isl_pkg::MODE_10B || m == isl_pkg::MODE_10B_SP;
  endfunction
  function automatic logic mode_ok(input logic [3:0] m);
    return m == isl_pkg::MODE_7B || m == isl_pkg::MODE_10B ||
           m == isl_pkg::MODE_7B_SP || m == isl_pkg::MODE_10B_SP;
  endfunction

  logic scl_rise, scl_fall, start_c, stop_c, match, req, third;
  logic scl_v, sda_v;
  assign scl_v    = (s_reg.scl_s[2] == s_reg.scl_s[1]) ? s_reg.scl_s[1]
                                                       : s_reg.scl_f;
  assign sda_v    = (s_reg.sda_s[2] == s_reg.sda_s[1]) ? s_reg.sda_s[1]
                                                       : s_reg.sda_f;
  assign scl_rise = scl_v & ~s_reg.scl_f;
  assign scl_fall = ~scl_v & s_reg.scl_f;
  assign start_c  = s_reg.scl_f & scl_v & s_reg.sda_f & ~sda_v;
  assign stop_c   = s_reg.scl_f & scl_v & ~s_reg.sda_f & sda_v;
  assign req      = (avs_read | avs_write) & ~s_reg.ack_bus;
  // read after a matched low byte in the same transaction
  assign third    = ten_bit(s_reg.mode) && s_reg.sr[0] && s_reg.hi_ok &&
                    (s_reg.sr[7:3] == isl_pkg::TEN_PREFIX);

  always_comb begin
    s_next = s_reg;
    match  = 1'b0;
    s_next.scl_s = {s_reg.scl_s[1:0], bus.scl};
    s_next.sda_s = {s_reg.sda_s[1:0], bus.sda};
    s_next.scl_f = scl_v;
    s_next.sda_f = sda_v;
    s_next.ack_bus = req;
    s_next.rdata = 32'h0000_0000;
    // register access
    if (req && avs_read) begin
      unique case (avs_address)
        isl_pkg::CTRL_IDX: s_next.rdata = {22'h0, s_reg.evt, s_reg.str,
          1'b0, s_reg.ov, s_reg.en, s_reg.rel, s_reg.mode};
        isl_pkg::STAT_IDX: s_next.rdata = {26'h0, s_reg.da, s_reg.sp,
          s_reg.st, s_reg.rw, s_reg.ua, s_reg.bf};
        isl_pkg::BUF_IDX: begin
          s_next.rdata = {24'h0, s_reg.buff};
          s_next.bf    = 1'b0;
        end
        isl_pkg::ADDR_IDX: s_next.rdata = {24'h0, s_reg.own};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (req && avs_write) begin
      unique case (avs_address)
        isl_pkg::CTRL_IDX: begin
          s_next.mode = avs_writedata[isl_pkg::CTRL_MODE_LSB +: 4];
          s_next.rel  = avs_writedata[isl_pkg::CTRL_REL];
          s_next.en   = avs_writedata[isl_pkg::CTRL_EN];
          s_next.ov   = avs_writedata[isl_pkg::CTRL_OV];
          s_next.str  = avs_writedata[isl_pkg::CTRL_STR];
          s_next.evt  = avs_writedata[isl_pkg::CTRL_EVT];
        end
        isl_pkg::BUF_IDX: begin
          s_next.buff = avs_writedata[7:0];
          s_next.sr   = avs_writedata[7:0];
          s_next.bf   = 1'b1;
        end
        isl_pkg::ADDR_IDX: begin
          s_next.own = avs_writedata[7:0];
          s_next.ua  = 1'b0;
        end
        default: ;
      endcase
    end
    // release waits for scl seen low, then the slave lets go of it
    if (s_reg.scl_oe && s_reg.rel && !s_reg.ua && !scl_v &&
        !(s_reg.ph == S_TX && s_reg.cnt == 4'h0 &&
          s_reg.sda_oe != ~s_reg.sr[7]))
      s_next.scl_oe = 1'b0;
    if (!s_reg.rel || s_reg.ua) s_next.scl_oe = s_reg.scl_oe;
    // bus events
    if (start_c) begin
      s_next.ph  = S_ADDR;
      s_next.cnt = 4'hF;
      s_next.st  = 1'b1;
      s_next.sp  = 1'b0;
      s_next.sda_oe = 1'b0;
      if (s_reg.mode[3]) s_next.evt = 1'b1;
    end else if (stop_c) begin
      s_next.ph  = S_IDLE;
      s_next.sp  = 1'b1;
      s_next.st  = 1'b0;
      s_next.hi_ok = 1'b0;
      s_next.sda_oe = 1'b0;
      if (s_reg.mode[3]) s_next.evt = 1'b1;
    end else if (s_reg.ph != S_IDLE) begin
      if (scl_rise) begin
        if (s_reg.cnt < 4'h8)
          s_next.sr = {s_reg.sr[6:0], sda_v};
        if (s_reg.ph == S_TXACK && s_reg.cnt == 4'h8) begin
          s_next.nak = sda_v;
        end
      end
      if (scl_fall) begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == 4'h7 && (s_reg.ph == S_ADDR || s_reg.ph == S_RX))
        begin
          if (s_reg.ph == S_ADDR) begin
            if (ten_bit(s_reg.mode))
              match = (s_reg.sr[7:3] == isl_pkg::TEN_PREFIX) ?
                (s_reg.sr[7:1] == s_reg.own[7:1]) :
                (s_reg.sr == s_reg.own);
            else
              match = s_reg.sr[7:1] == s_reg.own[7:1];
          end else begin
            match = 1'b1;
          end
          if (match) begin
            s_next.ack = !(s_reg.bf || s_reg.ov);
            if (!s_reg.bf && !s_reg.ov) begin
              s_next.buff   = s_reg.sr;
              s_next.bf     = 1'b1;
              s_next.sda_oe = 1'b1;
            end else s_next.ov = 1'b1;
            s_next.da = (s_reg.ph == S_RX);
            if (s_reg.ph == S_ADDR) begin
              s_next.rw = ten_bit(s_reg.mode) ? third
                                              : s_reg.sr[0];
              s_next.ua = ten_bit(s_reg.mode) && !third;
            end
          end else begin
            s_next.ph = S_SKIP;
          end
        end else if (s_reg.cnt == 4'h8) begin
          // ninth fall: flag, stretch, next phase
          s_next.cnt    = 4'h0;
          s_next.sda_oe = 1'b0;
          if (s_reg.ph == S_ADDR || s_reg.ph == S_RX) begin
            s_next.evt = 1'b1;
            if (s_reg.ph == S_ADDR && s_reg.rw &&
                (!ten_bit(s_reg.mode) || !s_reg.ua)) begin
              s_next.ph  = S_TX;
              s_next.bf  = 1'b0;
              s_next.rel = 1'b0;
              s_next.scl_oe = 1'b1;
            end else begin
              s_next.ph = S_RX;
              if (ten_bit(s_reg.mode) && s_reg.ph == S_ADDR) begin
                s_next.scl_oe = s_reg.ua;
                // high byte: stay in address phase for the low byte
                if (s_reg.sr[7:3] == isl_pkg::TEN_PREFIX) begin
                  s_next.ph    = S_ADDR;
                  s_next.hi_ok = 1'b0;
                end else begin
                  s_next.hi_ok = 1'b1;
                end
              end else if (s_reg.ph == S_RX && s_reg.str && s_reg.bf) begin
                s_next.rel    = 1'b0;
                s_next.scl_oe = 1'b1;
              end
            end
          end else if (s_reg.ph == S_TXACK) begin
            if (s_reg.nak) begin
              s_next.ph = S_IDLE;
              s_next.rw = 1'b0;
              s_next.da = 1'b0;
              s_next.bf = 1'b0;
            end else begin
              s_next.ph = S_TX;
              s_next.evt = 1'b1;
              s_next.da = 1'b1;
              if (!s_reg.bf) begin
                s_next.rel    = 1'b0;
                s_next.scl_oe = 1'b1;
              end
            end
          end else s_next.ph = S_SKIP;
        end
      end
      // transmit data on scl low
      if (s_reg.ph == S_TX && !scl_v && s_reg.rel &&
          (scl_fall || s_reg.cnt == 4'h0) && s_reg.cnt < 4'h8) begin
        s_next.sda_oe = ~s_reg.sr[7];
      end
      if (s_reg.ph == S_TX && scl_fall && s_reg.cnt == 4'h7) begin
        s_next.ph = S_TXACK;
        s_next.sda_oe = 1'b0;
        s_next.bf = 1'b0;
      end
    end
    if (!s_reg.en || !mode_ok(s_reg.mode)) begin
      s_next.ph = S_IDLE;
      s_next.scl_oe = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.st = 1'b0;
      s_next.sp = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
        ph: S_IDLE, own: isl_pkg::ADDR_RST, rel: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = ~s_reg.ack_bus;
  assign bus.scl_oe_dev  = s_reg.scl_oe;
  assign bus.sda_oe_dev  = s_reg.sda_oe;
endmodule

// ===== rtl/isl_master.sv
// Purpose: simple i2c master that drives the slave engine
// Assumes: one byte per command, start/stop generated only when the command asks for them
// Notes: honours clock stretching by waiting for scl high
`timescale 1ns/1ps
module isl_master (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // command
  input  wire logic       cmd_go,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_busy,
  output logic            cmd_done,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack,
  // i2c pins
  isl_bus_if.mst          bus
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_END}
    isl_mph_t;
  typedef struct packed {
    isl_mph_t   ph;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    logic [7:0] tmr;
    logic [3:0] bitn;
    logic       half;
    logic [8:0] sh;
    logic       stop;
    logic       rd;
    logic       scl_oe;
    logic       sda_oe;
    logic       busy;
    logic       done;
    logic [7:0] rdat;
    logic       ack;
  } isl_mst_t;
  isl_mst_t m_reg, m_next;
  logic scl_v, sda_v, tdone;
  assign scl_v = (m_reg.scl_s[2] == m_reg.scl_s[1]) ? m_reg.scl_s[1]
                                                    : m_reg.scl_f;
  assign sda_v = (m_reg.sda_s[2] == m_reg.sda_s[1]) ? m_reg.sda_s[1]
                                                    : m_reg.sda_f;
  assign tdone = m_reg.tmr == 8'h00;

  always_comb begin
    m_next = m_reg;
    m_next.scl_s = {m_reg.scl_s[1:0], bus.scl};
    m_next.sda_s = {m_reg.sda_s[1:0], bus.sda};
    m_next.scl_f = scl_v;
    m_next.sda_f = sda_v;
    m_next.done  = 1'b0;
    if (!tdone) m_next.tmr = m_reg.tmr - 8'h01;
    unique case (m_reg.ph)
      M_IDLE: if (cmd_go) begin
        m_next.busy = 1'b1;
        m_next.stop = cmd_stop;
        m_next.rd   = cmd_read;
        m_next.sh   = cmd_read ? {8'hFF, cmd_nack} : {cmd_data, 1'b1};
        m_next.bitn = 4'h0;
        m_next.half = 1'b0;
        m_next.tmr  = 8'(isl_pkg::SCL_HALF_CYC);
        m_next.ph   = cmd_start ? M_START : M_BIT;
      end
      M_START: if (tdone && m_reg.scl_oe && !m_reg.sda_oe) begin
        m_next.scl_oe = 1'b0;
        m_next.tmr = 8'(isl_pkg::SCL_HALF_CYC);
      end else if (tdone && scl_v) begin
        if (!m_reg.sda_oe) begin
          m_next.sda_oe = 1'b1;
          m_next.tmr = 8'(isl_pkg::SCL_HALF_CYC);
        end else begin
          m_next.scl_oe = 1'b1;
          m_next.tmr = 8'(isl_pkg::SCL_HALF_CYC);
          m_next.ph  = M_BIT;
        end
      end
      M_BIT: if (m_reg.half && !m_reg.scl_oe && !scl_v) begin
        // high time counts from scl seen high, not from release
        m_next.tmr = 8'(isl_pkg::SCL_HALF_CYC);
      end else if (tdone) begin
        if (!m_reg.half) begin
          m_next.sda_oe = ~m_reg.sh[8];
          m_next.half   = 1'b1;
          m_next.tmr    = 8'(isl_pkg::SCL_HALF_CYC);
        end else if (m_reg.scl_oe) begin
          m_next.scl_oe = 1'b0;
          m_next.tmr    = 8'(isl_pkg::SCL_HALF_CYC);
        end else begin
          m_next.sh     = {m_reg.sh[7:0], sda_v};
          m_next.scl_oe = 1'b1;
          m_next.tmr    = 8'(isl_pkg::SCL_HALF_CYC);
          m_next.bitn   = m_reg.bitn + 4'h1;
          if (m_reg.bitn == 4'h8) begin
            m_next.rdat = m_reg.sh[7:0];
            m_next.ack  = ~sda_v;
            m_next.ph   = m_reg.stop ? M_STOP : M_END;
          end else begin
            m_next.sda_oe = ~m_reg.sh[7];
          end
        end
      end
      M_STOP: if (tdone) begin
        if (m_reg.scl_oe) begin
          m_next.sda_oe = 1'b1;
          m_next.scl_oe = 1'b0;
          m_next.tmr = 8'(isl_pkg::SCL_HALF_CYC);
        end else if (scl_v) begin
          m_next.sda_oe = 1'b0;
          m_next.ph = M_END;
        end
      end
      M_END: begin
        if (!m_reg.stop) m_next.sda_oe = 1'b0;
        m_next.busy = 1'b0;
        m_next.done = 1'b1;
        m_next.ph   = M_IDLE;
      end
      default: m_next.ph = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      m_reg <= '{ph: M_IDLE, scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1,
        sda_f: 1'b1, default: '0};
    end else begin
      m_reg <= m_next;
    end
  end

  assign cmd_busy       = m_reg.busy;
  assign cmd_done       = m_reg.done;
  assign rsp_data       = m_reg.rdat;
  assign rsp_ack        = m_reg.ack;
  assign bus.scl_oe_mst = m_reg.scl_oe;
  assign bus.sda_oe_mst = m_reg.sda_oe;
endmodule

// ===== dv/isl_sva.sv
// Purpose: wire checks between slave engine and bus master
// Assumes: one clock domain, rstn async active low
// Notes: inputs are mclk, rstn and the interface signals only
`timescale 1ns/1ps
module isl_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // open-drain pair
  input wire logic scl_oe_dev,
  input wire logic sda_oe_dev,
  input wire logic scl_oe_mst,
  input wire logic sda_oe_mst,
  input wire logic scl,
  input wire logic sda
);
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_reset_quiet: assert property (
    $rose(rstn) |-> !scl_oe_dev && !sda_oe_dev)
    else $error("slave drives a pin after reset");
  chk_wire_level: assert property (
    (scl == !(scl_oe_dev || scl_oe_mst)) &&
    (sda == !(sda_oe_dev || sda_oe_mst)))
    else $error("wire level differs from enables");
  chk_sda_on_low: assert property (
    $changed(sda_oe_dev) |-> !scl)
    else $error("slave moved sda while scl high");
  chk_scl_grab_low: assert property (
    $rose(scl_oe_dev) |-> !$past(scl))
    else $error("slave pulled scl low while it was high");
  chk_scl_high_min: assert property (
    $rose(scl) |=> scl [*8])
    else $error("scl high time cut short");
  chk_release_rise: assert property (
    $fell(scl_oe_dev) && !scl_oe_mst |-> ##[0:200] scl)
    else $error("scl stayed low after slave release");
  chk_sda_setup: assert property (
    $rose(scl) |=> $stable(sda) [*4])
    else $error("sda moved just after scl rise");
  chk_stop_release: assert property (
    $rose(sda) && scl && $past(scl) |=> !sda_oe_dev [*8])
    else $error("slave drives sda after stop");

  cov_stretch: cover property ($rose(scl_oe_dev));
  cov_slave_ack: cover property (sda_oe_dev && $rose(scl));
  cov_stop: cover property ($rose(sda) && scl);
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench joining slave engine and bus master
// Assumes: 50 MHz mclk, software side played by tasks here
// Notes: master sends one byte per command
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0] f;
    logic [7:0] d;
    logic       ack;
    logic       da;
  } isl_row_t;
  logic        mclk;
  logic        rstn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cmd_go;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cmd_read;
  logic        cmd_nack;
  logic [7:0]  cmd_data;
  logic        cmd_busy;
  logic        cmd_done;
  logic [7:0]  rsp_data;
  logic        rsp_ack;
  logic [31:0] q;
  logic [3:0]  md;
  logic        sn;
  int          errors;
  int          n_tests;
  int          cyc;
  isl_row_t    rows [4];

  isl_bus_if bus ();
  isl_slave isl_slave_inst (.mclk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .bus(bus));
  isl_master isl_master_inst (.mclk, .rstn, .cmd_go, .cmd_start,
    .cmd_stop, .cmd_read, .cmd_nack, .cmd_data, .cmd_busy, .cmd_done,
    .rsp_data, .rsp_ack, .bus(bus));
  isl_sva isl_sva_inst (.mclk, .rstn, .scl_oe_dev(bus.scl_oe_dev),
    .sda_oe_dev(bus.sda_oe_dev), .scl_oe_mst(bus.scl_oe_mst),
    .sda_oe_mst(bus.sda_oe_mst), .scl(bus.scl), .sda(bus.sda));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chkv(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic fs(input int b, input logic e);
    av(1'b0, isl_pkg::STAT_IDX, 32'h0);
    chkb(q[b], e);
  endtask
  task automatic fc(input int b, input logic e);
    av(1'b0, isl_pkg::CTRL_IDX, 32'h0);
    chkb(q[b], e);
  endtask
  task automatic bv(input logic [7:0] e);
    av(1'b0, isl_pkg::BUF_IDX, 32'h0);
    chkv(q[7:0], e);
  endtask
  task automatic clr();
    av(1'b1, isl_pkg::CTRL_IDX, {22'h0, 1'b0, sn, 4'h3, md});
  endtask
  task automatic held(input logic e);
    repeat (10) @(posedge mclk);
    chkb(bus.scl_oe_dev, e);
  endtask
  task automatic go(input logic [3:0] f, input logic [7:0] d);
    @(posedge mclk);
    {cmd_start, cmd_stop, cmd_read, cmd_nack} <= f;
    cmd_data <= d;
    cmd_go <= 1'b1;
    do @(posedge mclk); while (cmd_busy !== 1'b1);
    cmd_go <= 1'b0;
  endtask
  task automatic fin();
    do @(posedge mclk); while (cmd_done !== 1'b1);
    repeat (8) @(posedge mclk);
  endtask
  task automatic xf(input logic [3:0] f, input logic [7:0] d);
    go(f, d);
    fin();
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc == 100000) begin
        errors++;
        $display("MISMATCH t=%0t timeout", $time);
        complete_run();
      end
    end
  end
  initial begin
    rstn = 1'b0;
    errors = 0;
    n_tests = 0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    {cmd_go, cmd_start, cmd_stop, cmd_read, cmd_nack} = 5'h0;
    cmd_data = 8'h00;
    md = isl_pkg::MODE_7B;
    sn = 1'b0;
    rows[0] = '{4'h8, 8'hA0, 1'b1, 1'b0};
    rows[1] = '{4'h0, 8'h3C, 1'b1, 1'b1};
    rows[2] = '{4'h4, 8'hC3, 1'b1, 1'b1};
    rows[3] = '{4'hC, 8'hB0, 1'b0, 1'b0};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    fc(isl_pkg::CTRL_REL, 1'b1);
    fs(isl_pkg::ST_BF, 1'b0);
    av(1'b1, isl_pkg::ADDR_IDX, 32'hA0);
    clr();
    for (int i = 0; i < 4; i++) begin
      xf(rows[i].f, rows[i].d);
      chkb(rsp_ack, rows[i].ack);
      fc(isl_pkg::CTRL_EVT, rows[i].ack);
      if (rows[i].ack) begin
        fs(isl_pkg::ST_BF, 1'b1);
        fs(isl_pkg::ST_DA, rows[i].da);
        fs(isl_pkg::ST_RW, 1'b0);
        bv(rows[i].d);
        fs(isl_pkg::ST_BF, 1'b0);
      end
      clr();
    end
    $display("end: write rows");
    md = isl_pkg::MODE_7B_SP;
    clr();
    xf(4'hC, 8'hB0);
    fc(isl_pkg::CTRL_EVT, 1'b1);
    md = isl_pkg::MODE_7B;
    clr();
    xf(4'h8, 8'hA0);
    xf(4'h0, 8'h11);
    chkb(rsp_ack, 1'b0);
    fc(isl_pkg::CTRL_OV, 1'b1);
    fc(isl_pkg::CTRL_EVT, 1'b1);
    bv(8'hA0);
    fc(isl_pkg::CTRL_OV, 1'b1);
    clr();
    fc(isl_pkg::CTRL_OV, 1'b0);
    xf(4'hC, 8'hB0);
    $display("end: events and overflow");
    xf(4'h8, 8'hA1);
    held(1'b1);
    fs(isl_pkg::ST_RW, 1'b1);
    bv(8'hA1);
    go(4'h2, 8'h00);
    av(1'b1, isl_pkg::BUF_IDX, 32'h5A);
    clr();
    fin();
    chkv(rsp_data, 8'h5A);
    held(1'b1);
    go(4'h7, 8'h00);
    av(1'b1, isl_pkg::BUF_IDX, 32'h96);
    clr();
    fin();
    chkv(rsp_data, 8'h96);
    fs(isl_pkg::ST_RW, 1'b0);
    $display("end: transmit");
    sn = 1'b1;
    clr();
    xf(4'h8, 8'hA0);
    repeat (10) @(posedge mclk);
    bv(8'hA0);
    clr();
    xf(4'h0, 8'h77);
    held(1'b1);
    bv(8'h77);
    clr();
    held(1'b0);
    xf(4'hC, 8'hB0);
    sn = 1'b0;
    $display("end: stretch");
    for (int k = 0; k < 2; k++) begin
      md = k ? isl_pkg::MODE_10B_SP : isl_pkg::MODE_10B;
      clr();
      av(1'b1, isl_pkg::ADDR_IDX, 32'hF2);
      xf(4'h8, 8'hF2);
      chkb(rsp_ack, 1'b1);
      held(1'b1);
      fs(isl_pkg::ST_UA, 1'b1);
      av(1'b1, isl_pkg::ADDR_IDX, 32'h34);
      held(1'b0);
      bv(8'hF2);
      xf(4'h0, 8'h34);
      chkb(rsp_ack, 1'b1);
      fs(isl_pkg::ST_UA, 1'b1);
      av(1'b1, isl_pkg::ADDR_IDX, 32'hF2);
      bv(8'h34);
      xf(4'h0, 8'hAB);
      bv(8'hAB);
      xf(4'h8, 8'hF3);
      fs(isl_pkg::ST_UA, 1'b0);
      bv(8'hF3);
      go(4'h7, 8'h00);
      av(1'b1, isl_pkg::BUF_IDX, 32'hC5);
      clr();
      fin();
      chkv(rsp_data, 8'hC5);
      $display("end: ten-bit pass %0d", k);
    end
    complete_run();
  end
endmodule
